/* File: core/oscsec_ctrl.sv */
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module oscsec_ctrl
    import oscsec_pkg::*;
#(
    parameter int STARTUP_UNIT = OSCSEC_STARTUP_UNIT
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic write_lock,
    input wire logic debug_halt,
    input wire logic debugger_access,
    input wire logic debugger_connected,
    input wire logic brownout_detect,
    output logic brownout_reset_req,
    input wire logic sleep_idle,
    input wire logic sleep_standby,
    input wire logic periph_req,
    output logic ext_osc_run,
    output logic ext_osc_clk_unmask,
    output logic ext_osc_crystal,
    output logic osc_input_pin_override,
    output logic osc_output_pin_override,
    output logic [OSCSEC_XC_GAIN_W-1:0] ext_osc_gain,
    output logic ext_osc_auto_amp,
    output logic ultra_low_power_osc_run,
    output logic irq,
    output logic wake_req
);

    logic [31:0] extosc_ctrl;
    logic [31:0] next_extosc_ctrl;
    logic [31:0] supply_ctrl;
    logic [31:0] next_supply_ctrl;
    logic [OSCSEC_EV_W-1:0] inten;
    logic [OSCSEC_EV_W-1:0] next_inten;
    logic [OSCSEC_EV_W-1:0] interrupt_flag_register;
    logic [OSCSEC_EV_W-1:0] next_interrupt_flag_register;
    logic ready_q;
    logic next_ready_q;
    logic bod_q;
    logic next_bod_q;
    logic [31:0] next_prdata;
    logic [31:0] next_ext_regs;

    logic ext_ready;
    logic ext_run;
    logic setup_ph;
    logic access_ph;
    logic wr_ok;
    logic locked;
    logic mapped;
    logic [31:0] wmask;
    logic [OSCSEC_EV_W-1:0] events;
    logic [OSCSEC_EV_W-1:0] status;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == OSCSEC_ADDR_INTEN_CLR) || (a == OSCSEC_ADDR_INTEN_SET)
            || (a == OSCSEC_ADDR_INTERRUPT_FLAG_REGISTER) || (a == OSCSEC_ADDR_STATUS)
            || (a == OSCSEC_ADDR_EXTOSC) || (a == OSCSEC_ADDR_SUPPLY);
    endfunction

    // Byte enables widened to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    oscsec_run_ctrl #(
        .UNIT(STARTUP_UNIT)
    ) u_ext_run (
        .pclk(pclk),
        .presetn(presetn),
        .enable(extosc_ctrl[OSCSEC_XC_ENABLE]),
        .on_request(extosc_ctrl[OSCSEC_XC_ONREQ]),
        .run_standby(extosc_ctrl[OSCSEC_XC_STANDBY]),
        .sleep_idle(sleep_idle),
        .sleep_standby(sleep_standby),
        .periph_req(periph_req),
        .startup(extosc_ctrl[OSCSEC_XC_START_LSB +: OSCSEC_XC_START_W]),
        .run(ext_run),
        .ready(ext_ready)
    );

    // Bus decode; the debug halt never stalls this logic, only unlocks it
    always_comb
    begin
        setup_ph = psel && !penable;
        access_ph = psel && penable;
        mapped = is_mapped(paddr);
        locked = write_lock && !debug_halt && !debugger_access;
        // The flag register is exempt so a pending interrupt can always be acked
        wr_ok = access_ph && pwrite && mapped
            && (!locked || paddr == OSCSEC_ADDR_INTERRUPT_FLAG_REGISTER);
        wmask = lane_mask(pstrb);
        pready = access_ph;
        pslverr = access_ph && (!mapped || (pwrite && !wr_ok));
    end

    // Events: ready rising edge and brown-out rising edge
    always_comb
    begin
        next_ready_q = ext_ready;
        next_bod_q = brownout_detect;
        events = '0;
        events[OSCSEC_EV_EXTRDY] = ext_ready && !ready_q;
        events[OSCSEC_EV_BROWNOUT] = brownout_detect && !bod_q;
        status = '0;
        status[OSCSEC_EV_EXTRDY] = ext_ready;
        status[OSCSEC_EV_BROWNOUT] = brownout_detect;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ready_q <= 1'b0;
            bod_q <= 1'b0;
        end
        else
        begin
            ready_q <= next_ready_q;
            bod_q <= next_bod_q;
        end
    end

    // Control registers
    always_comb
    begin
        next_extosc_ctrl = extosc_ctrl;
        next_supply_ctrl = supply_ctrl;
        next_inten = inten;
        next_ext_regs = (extosc_ctrl & ~wmask) | (pwdata & wmask);
        if (wr_ok)
        begin
            unique case (paddr)
                OSCSEC_ADDR_EXTOSC:
                    next_extosc_ctrl = next_ext_regs & OSCSEC_XC_MASK;
                OSCSEC_ADDR_SUPPLY:
                    next_supply_ctrl[OSCSEC_SC_RSTEN] = pstrb[0]
                        ? pwdata[OSCSEC_SC_RSTEN] : supply_ctrl[OSCSEC_SC_RSTEN];
                OSCSEC_ADDR_INTEN_SET:
                    next_inten = inten | (pwdata[OSCSEC_EV_W-1:0] & wmask[OSCSEC_EV_W-1:0]);
                OSCSEC_ADDR_INTEN_CLR:
                    next_inten = inten & ~(pwdata[OSCSEC_EV_W-1:0] & wmask[OSCSEC_EV_W-1:0]);
                default:
                    next_inten = inten;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            extosc_ctrl <= OSCSEC_XC_RESET;
            supply_ctrl <= OSCSEC_SC_RESET;
            inten <= OSCSEC_INTEN_RESET;
        end
        else
        begin
            extosc_ctrl <= next_extosc_ctrl;
            supply_ctrl <= next_supply_ctrl;
            inten <= next_inten;
        end
    end

    // Flags: write one to clear; a same-cycle event wins over the clear
    always_comb
    begin
        next_interrupt_flag_register = interrupt_flag_register;
        if (wr_ok && paddr == OSCSEC_ADDR_INTERRUPT_FLAG_REGISTER)
            next_interrupt_flag_register = interrupt_flag_register & ~(pwdata[OSCSEC_EV_W-1:0] & wmask[OSCSEC_EV_W-1:0]);
        next_interrupt_flag_register = next_interrupt_flag_register | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            interrupt_flag_register <= '0;
        else
            interrupt_flag_register <= next_interrupt_flag_register;
    end

    // Read data captured in the setup cycle, presented in the access cycle
    always_comb
    begin
        next_prdata = prdata;
        if (setup_ph)
        begin
            next_prdata = '0;
            if (!pwrite)
            begin
                unique case (paddr)
                    OSCSEC_ADDR_INTEN_CLR:
                        next_prdata[OSCSEC_EV_W-1:0] = inten;
                    OSCSEC_ADDR_INTEN_SET:
                        next_prdata[OSCSEC_EV_W-1:0] = inten;
                    OSCSEC_ADDR_INTERRUPT_FLAG_REGISTER:
                        next_prdata[OSCSEC_EV_W-1:0] = interrupt_flag_register;
                    OSCSEC_ADDR_STATUS:
                        next_prdata[OSCSEC_EV_W-1:0] = status;
                    OSCSEC_ADDR_EXTOSC:
                        next_prdata = extosc_ctrl;
                    OSCSEC_ADDR_SUPPLY:
                        next_prdata = supply_ctrl;
                    default:
                        next_prdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else
            prdata <= next_prdata;
    end

    // Oscillator and pin outputs
    always_comb
    begin
        ext_osc_run = ext_run;
        ext_osc_clk_unmask = ext_ready;
        ext_osc_crystal = extosc_ctrl[OSCSEC_XC_CRYSTAL];
        osc_input_pin_override = extosc_ctrl[OSCSEC_XC_ENABLE];
        osc_output_pin_override = extosc_ctrl[OSCSEC_XC_ENABLE]
            && extosc_ctrl[OSCSEC_XC_CRYSTAL];
        ext_osc_auto_amp = extosc_ctrl[OSCSEC_XC_ENABLE]
            && extosc_ctrl[OSCSEC_XC_CRYSTAL] && extosc_ctrl[OSCSEC_XC_AUTOAMP];
        // Fixed gain only drives the amplifier while automatic control is off
        ext_osc_gain = ext_osc_auto_amp ? '0
            : extosc_ctrl[OSCSEC_XC_GAIN_LSB +: OSCSEC_XC_GAIN_W];
        ultra_low_power_osc_run = 1'b1;
        irq = |(interrupt_flag_register & inten);
        // Only the brown-out source may wake the part from standby
        wake_req = sleep_standby && interrupt_flag_register[OSCSEC_EV_BROWNOUT]
            && inten[OSCSEC_EV_BROWNOUT];
        brownout_reset_req = brownout_detect && supply_ctrl[OSCSEC_SC_RSTEN]
            && !debugger_connected;
    end

endmodule
`default_nettype wire

/* File: core/oscsec_pkg.sv */
`default_nettype none

package oscsec_pkg;

    // Register byte addresses
    localparam logic [7:0] OSCSEC_ADDR_INTEN_CLR = 8'h00;
    localparam logic [7:0] OSCSEC_ADDR_INTEN_SET = 8'h04;
    localparam logic [7:0] OSCSEC_ADDR_INTERRUPT_FLAG_REGISTER = 8'h08;
    localparam logic [7:0] OSCSEC_ADDR_STATUS = 8'h0c;
    localparam logic [7:0] OSCSEC_ADDR_EXTOSC = 8'h10;
    localparam logic [7:0] OSCSEC_ADDR_SUPPLY = 8'h14;

    // Interrupt, flag and status bit positions
    localparam int OSCSEC_EV_EXTRDY = 0;
    localparam int OSCSEC_EV_BROWNOUT = 1;
    localparam int OSCSEC_EV_W = 2;

    // Ext oscillator control fields
    localparam int OSCSEC_XC_ENABLE = 1;
    localparam int OSCSEC_XC_CRYSTAL = 2;
    localparam int OSCSEC_XC_AUTOAMP = 5;
    localparam int OSCSEC_XC_STANDBY = 6;
    localparam int OSCSEC_XC_ONREQ = 7;
    localparam int OSCSEC_XC_GAIN_LSB = 8;
    localparam int OSCSEC_XC_GAIN_W = 3;
    localparam int OSCSEC_XC_START_LSB = 12;
    localparam int OSCSEC_XC_START_W = 4;
    localparam logic [31:0] OSCSEC_XC_MASK = 32'h0000_f7e6;
    // Disabled, external clock mode, run on request
    localparam logic [31:0] OSCSEC_XC_RESET = 32'h0000_0080;

    // Supply control: bit 0 lets the brown-out detector request a reset
    localparam int OSCSEC_SC_RSTEN = 0;
    localparam logic [31:0] OSCSEC_SC_RESET = 32'h0000_0001;

    localparam logic [OSCSEC_EV_W-1:0] OSCSEC_INTEN_RESET = 2'h0;

    // Start-up time step per field count, in pclk cycles
    localparam int OSCSEC_STARTUP_UNIT = 256;
    localparam int OSCSEC_CNT_W = 16;

endpackage

`default_nettype wire

/* File: core/oscsec_run_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none

module oscsec_run_ctrl
    import oscsec_pkg::*;
#(
    parameter int UNIT = OSCSEC_STARTUP_UNIT
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic on_request,
    input wire logic run_standby,
    input wire logic sleep_idle,
    input wire logic sleep_standby,
    input wire logic periph_req,
    input wire logic [OSCSEC_XC_START_W-1:0] startup,
    output logic run,
    output logic ready
);

    logic [OSCSEC_CNT_W-1:0] cnt;
    logic [OSCSEC_CNT_W-1:0] next_cnt;
    logic next_ready;
    logic [OSCSEC_CNT_W-1:0] target;

    always_comb
    begin
        if (!enable)
            run = 1'b0;
        else if (sleep_standby)
            run = run_standby && (!on_request || periph_req);
        else if (sleep_idle)
            run = !on_request || periph_req;
        else
            run = 1'b1;
    end

    // Start-up time grows with the field so long crystals can settle
    always_comb
    begin
        target = OSCSEC_CNT_W'((int'(startup) + 1) * UNIT);
        next_cnt = cnt;
        next_ready = ready;
        if (!run)
        begin
            next_cnt = '0;
            next_ready = 1'b0;
        end
        else if (!ready)
        begin
            if (cnt + OSCSEC_CNT_W'(1) >= target)
                next_ready = 1'b1;
            else
                next_cnt = cnt + OSCSEC_CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= '0;
            ready <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            ready <= next_ready;
        end
    end

endmodule
`default_nettype wire

/* File: verif/oscsec_ctrl_monitor.sv */
`timescale 1ns/10ps
`default_nettype none

module oscsec_ctrl_monitor
    import oscsec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    input wire logic write_lock,
    input wire logic debug_halt,
    input wire logic debugger_access,
    input wire logic debugger_connected,
    input wire logic brownout_detect,
    input wire logic brownout_reset_req,
    input wire logic sleep_standby,
    input wire logic ext_osc_run,
    input wire logic ext_osc_clk_unmask,
    input wire logic ext_osc_crystal,
    input wire logic osc_input_pin_override,
    input wire logic osc_output_pin_override,
    input wire logic [OSCSEC_XC_GAIN_W-1:0] ext_osc_gain,
    input wire logic ext_osc_auto_amp,
    input wire logic ultra_low_power_osc_run,
    input wire logic wake_req
);
    logic wr;
    assign wr = psel && penable && pwrite;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ulp_always_on_a: assert property (ultra_low_power_osc_run)
        else $error("ultra low power oscillator stopped");
    run_needs_en_a: assert property (ext_osc_run |-> osc_input_pin_override)
        else $error("oscillator runs while disabled");
    pin_mode_a: assert property (osc_input_pin_override |-> osc_output_pin_override == ext_osc_crystal)
        else $error("pin takeover does not match mode");
    bor_block_a: assert property (brownout_reset_req |-> brownout_detect && !debugger_connected)
        else $error("brown-out reset not blocked");
    auto_gain_a: assert property (ext_osc_auto_amp |-> ext_osc_gain == '0 && ext_osc_crystal)
        else $error("fixed gain applied under auto amplitude");
    ready_drop_a: assert property (!ext_osc_run |=> !ext_osc_clk_unmask)
        else $error("ready kept after oscillator stopped");
    start_mask_a: assert property ($rose(ext_osc_clk_unmask) |-> $past(ext_osc_run) && $past(ext_osc_run, 2))
        else $error("output unmasked before start-up time");
    lock_err_a: assert property (wr && write_lock && !debug_halt && !debugger_access
        && paddr == OSCSEC_ADDR_EXTOSC |-> pslverr) else $error("locked write accepted");
    flag_free_a: assert property (wr && paddr == OSCSEC_ADDR_INTERRUPT_FLAG_REGISTER |-> !pslverr)
        else $error("flag register write refused");
    dbg_free_a: assert property (wr && (debug_halt || debugger_access)
        && paddr == OSCSEC_ADDR_EXTOSC |-> !pslverr) else $error("debug write refused");
    wake_a: assert property (wake_req |-> sleep_standby)
        else $error("wake request outside standby");
endmodule

bind oscsec_ctrl oscsec_ctrl_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr),
    .write_lock(write_lock), .debug_halt(debug_halt), .debugger_access(debugger_access),
    .debugger_connected(debugger_connected), .brownout_detect(brownout_detect),
    .brownout_reset_req(brownout_reset_req), .sleep_standby(sleep_standby),
    .ext_osc_run(ext_osc_run), .ext_osc_clk_unmask(ext_osc_clk_unmask),
    .ext_osc_crystal(ext_osc_crystal), .osc_input_pin_override(osc_input_pin_override),
    .osc_output_pin_override(osc_output_pin_override), .ext_osc_gain(ext_osc_gain),
    .ext_osc_auto_amp(ext_osc_auto_amp), .ultra_low_power_osc_run(ultra_low_power_osc_run),
    .wake_req(wake_req));

`default_nettype wire

/* File: verif/osc_sleep_enable_ctrl_test.sv */
`timescale 1ns/10ps
`default_nettype none

module osc_sleep_enable_ctrl_test
    import oscsec_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, write_lock, debug_halt, debugger_access;
    logic debugger_connected, brownout_detect, sleep_idle, sleep_standby, periph_req;
    logic pready, pslverr, err, brownout_reset_req, ext_osc_run, ext_osc_clk_unmask;
    logic ext_osc_crystal, osc_input_pin_override, osc_output_pin_override, ext_osc_auto_amp;
    logic ultra_low_power_osc_run, irq, wake_req, kb;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0] pstrb, st;
    logic [2:0] ext_osc_gain, g;
    int fails, n_compared, n, md;

    oscsec_ctrl #(.STARTUP_UNIT(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .write_lock(write_lock),
        .debug_halt(debug_halt), .debugger_access(debugger_access),
        .debugger_connected(debugger_connected), .brownout_detect(brownout_detect),
        .brownout_reset_req(brownout_reset_req), .sleep_idle(sleep_idle),
        .sleep_standby(sleep_standby), .periph_req(periph_req), .ext_osc_run(ext_osc_run),
        .ext_osc_clk_unmask(ext_osc_clk_unmask), .ext_osc_crystal(ext_osc_crystal),
        .osc_input_pin_override(osc_input_pin_override),
        .osc_output_pin_override(osc_output_pin_override), .ext_osc_gain(ext_osc_gain),
        .ext_osc_auto_amp(ext_osc_auto_amp), .ultra_low_power_osc_run(ultra_low_power_osc_run),
        .irq(irq), .wake_req(wake_req));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Awake: enable alone decides; standby also needs run_in_standby
    function automatic logic exp_run(input logic od, input logic rs, input int m, input logic p);
        return (m == 0) ? 1'b1 : (m == 1) ? (!od || p) : (rs && (!od || p));
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle limit here: only the watchdog may end a stuck transfer
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    // Counts edges until an output goes high: 0 selects unmask, 1 selects irq
    task automatic wait_for(input int which);
        n = 0;
        while ((which == 0 ? ext_osc_clk_unmask : irq) !== 1'b1 && n < 200)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (n >= 200)
        begin
            fails++;
            $display("MISMATCH t=%0t wait limit reached", $time);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        print_verdict();
    end

    initial
    begin
        {psel, penable, pwrite, write_lock, debug_halt, debugger_access} = '0;
        {debugger_connected, brownout_detect, sleep_idle, sleep_standby, periph_req} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        presetn = 1'b0;
        fails = 0;
        n_compared = 0;
        seed = 32'h0001_3314;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OSCSEC_ADDR_EXTOSC, '0);
        chk(rd, OSCSEC_XC_RESET);
        chk(32'({ext_osc_run, osc_input_pin_override, osc_output_pin_override}), '0);
        apb(1'b0, OSCSEC_ADDR_SUPPLY, '0);
        chk(rd, OSCSEC_SC_RESET);
        $display("test reset done");
        for (int k = 0; k < 2; k++)
        begin
            seed = lfsr(seed);
            st = {2'b00, seed[1:0]};
            g = seed[4:2];
            kb = k[0];
            apb(1'b1, OSCSEC_ADDR_EXTOSC, 32'h0000_0080);
            apb(1'b1, OSCSEC_ADDR_EXTOSC,
                {16'h0, st, 1'b0, g, 2'b10, kb, 2'b00, kb, 2'b10});
            wait_for(0);
            chk(32'(n), 32'((st + 1) * 2));
            chk(32'({ext_osc_crystal, osc_input_pin_override, osc_output_pin_override}),
                32'({kb, 1'b1, kb}));
            chk(32'({ext_osc_auto_amp, ext_osc_gain}), 32'({kb, kb ? 3'h0 : g}));
            apb(1'b0, OSCSEC_ADDR_STATUS, '0);
            chk(32'(rd[OSCSEC_EV_EXTRDY]), 32'h0000_0001);
        end
        $display("test start-up done");
        apb(1'b1, OSCSEC_ADDR_INTEN_SET, 32'h0000_0003);
        apb(1'b1, OSCSEC_ADDR_EXTOSC, 32'h0000_0080);
        chk(32'(ext_osc_run), '0);
        // Ready is a flop and drops one edge after the oscillator stops
        @(posedge pclk);
        #1;
        chk(32'(ext_osc_clk_unmask), '0);
        apb(1'b1, OSCSEC_ADDR_INTERRUPT_FLAG_REGISTER, 32'h0000_0001);
        chk(32'(irq), '0);
        apb(1'b1, OSCSEC_ADDR_EXTOSC, 32'h0000_0082);
        wait_for(1);
        chk(32'(n), 32'h0000_0003);
        write_lock <= 1'b1;
        apb(1'b1, OSCSEC_ADDR_INTERRUPT_FLAG_REGISTER, 32'h0000_0001);
        chk(32'({err, irq}), '0);
        apb(1'b1, OSCSEC_ADDR_EXTOSC, 32'h0000_0080);
        chk(32'({err, ext_osc_run}), 32'h0000_0003);
        debug_halt <= 1'b1;
        apb(1'b1, OSCSEC_ADDR_EXTOSC, 32'h0000_0080);
        chk(32'({err, ext_osc_run}), '0);
        apb(1'b1, OSCSEC_ADDR_EXTOSC, 32'h0000_0082);
        wait_for(0);
        chk(32'(n), 32'h0000_0002);
        debug_halt <= 1'b0;
        debugger_access <= 1'b1;
        apb(1'b1, OSCSEC_ADDR_EXTOSC, 32'h0000_0080);
        chk(32'({err, ext_osc_run}), '0);
        debugger_access <= 1'b0;
        write_lock <= 1'b0;
        apb(1'b0, 8'h40, '0);
        chk({rd[30:0], err}, 32'h0000_0001);
        $display("test lock done");
        for (int c = 0; c < 4; c++)
        begin
            sleep_idle <= 1'b0;
            apb(1'b1, OSCSEC_ADDR_EXTOSC, {24'h0, c[0], c[1], 6'h02});
            // Standby is only entered once the oscillator reports ready
            wait_for(0);
            for (int m = 0; m < 6; m++)
            begin
                md = (m < 2) ? 0 : (m < 4) ? 2 : 1;
                seed = lfsr(seed);
                sleep_idle <= (md == 1);
                sleep_standby <= (md == 2);
                periph_req <= seed[0];
                @(posedge pclk);
                #1;
                chk(32'(ext_osc_run), 32'(exp_run(c[0], c[1], md, seed[0])));
                chk(32'(ultra_low_power_osc_run), 32'h0000_0001);
            end
        end
        $display("test sleep done");
        // Oscillator off, so standby cannot start during a start-up
        apb(1'b1, OSCSEC_ADDR_EXTOSC, 32'h0000_0080);
        sleep_idle <= 1'b0;
        sleep_standby <= 1'b1;
        brownout_detect <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        chk(32'({brownout_reset_req, wake_req}), 32'h0000_0003);
        debugger_connected <= 1'b1;
        sleep_standby <= 1'b0;
        @(posedge pclk);
        #1;
        chk(32'({brownout_reset_req, wake_req}), '0);
        apb(1'b1, OSCSEC_ADDR_INTEN_CLR, 32'h0000_0002);
        apb(1'b0, OSCSEC_ADDR_INTEN_SET, '0);
        chk(rd, 32'h0000_0001);
        $display("test brown-out done");
        print_verdict();
    end
endmodule

`default_nettype wire
